/* File: hdl/timer_pair_mode_control.sv */
// What this block does
// RULE1 - A capture-select bit picks plain timer/counter (0) or capture (1).
// RULE2 - A count-continue bit of 0 holds the count; 1 resumes from it. Here the write that sets it with start clears, so counting restarts at 0.
// RULE3 - A start bit of 0 stops counting; writing 1 clears and restarts.
// RULE4 - Timer A clock code 000 is /2, 010..110 /2^3../2^11, 111 the pin.
// RULE5 - Timer C clock codes 000..110 are /2,/2^2../2^12; 111 gives none.
// RULE6 - Reset clears every bit of the timer C mode register.
// RULE7 - With the pin clock, each rising edge of the pin counts once.
// RULE8 - In capture mode counting goes on and an edge copies the count.
// RULE9 - In timer mode a count equal to the data register clears and flags.
`timescale 1ns/1ps
`default_nettype none
module timer_pair_mode_control
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Pins
    input wire logic external_event_input,
    input wire logic capture_a_pin,
    input wire logic capture_c_pin,
    // Interrupt
    output logic irq
);

    // ********************************
    // Declarations
    // ********************************
    mode_t mode [NUM_TIMERS];
    logic [DATA_W-1:0] data_reg [NUM_TIMERS];
    logic [DATA_W-1:0] count [NUM_TIMERS];
    logic [DATA_W-1:0] capt [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] tick;
    logic [NUM_TIMERS-1:0] run;
    logic [NUM_TIMERS-1:0] start_wr;
    logic [NUM_TIMERS-1:0] match_hit;
    logic [NUM_TIMERS-1:0] capt_hit;
    logic [NUM_TIMERS-1:0] capt_rise;
    logic [DIV_MAX:1] div_tick;
    logic event_rise;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_enable;
    logic [EV_W-1:0] irq_set;
    logic [EV_W-1:0] irq_clear;
    logic [DATA_W-1:0] next_rdata;
    logic [ADDR_W-1:0] mode_addr [NUM_TIMERS];
    logic [ADDR_W-1:0] data_addr [NUM_TIMERS];

    assign mode_addr[TIMER_A] = ADDR_MODE_A;
    assign mode_addr[TIMER_C] = ADDR_MODE_C;
    assign data_addr[TIMER_A] = ADDR_DATA_A;
    assign data_addr[TIMER_C] = ADDR_DATA_C;

    // ********************************
    // Rate sources
    // ********************************
    // One divider shared, so both timers see aligned rates
    clock_prescaler u_prescaler (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .div_tick(div_tick)
    );

    // Pins cross into ref_clk before any edge is judged
    edge_sync #(.W(3)) u_pin_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_in({capture_c_pin, capture_a_pin, external_event_input}),
        .rise_out({capt_rise[TIMER_C], capt_rise[TIMER_A], event_rise})
    );

    // ********************************
    // Per-timer logic
    // ********************************
    for (genvar i = 0; i < NUM_TIMERS; i++)
    begin : g_timer
        int exp_sel;

        // RULE4 RULE5 clock code decode
        assign exp_sel = div_exponent(mode[i].clk_sel, i == TIMER_C);

        always_comb
        begin
            tick[i] = 1'b0;
            if (exp_sel != 0)
                tick[i] = div_tick[exp_sel];
            // RULE7 pin edge as clock
            else if (i == TIMER_A)
                tick[i] = event_rise;
        end

        // RULE2 RULE3 counting needs both bits
        assign run[i] = mode[i].start_clear & mode[i].count_continue;
        assign start_wr[i] = reg_wr && reg_addr == mode_addr[i] &&
                             reg_wdata[0];
        // RULE9 match only outside capture mode
        assign match_hit[i] = run[i] && tick[i] && !start_wr[i] &&
                              !mode[i].capture && count[i] == data_reg[i];
        // RULE1 RULE8 capture select gates the copy
        assign capt_hit[i] = mode[i].capture && capt_rise[i];

        // RULE6 mode bits clear at reset
        always_ff @(posedge ref_clk or posedge sys_rst)
        begin
            if (sys_rst)
                mode[i] <= MODE_RESET;
            else if (reg_wr && reg_addr == mode_addr[i])
                mode[i] <= mode_t'(reg_wdata[MODE_W-1:0]);
        end

        always_ff @(posedge ref_clk or posedge sys_rst)
        begin
            if (sys_rst)
                data_reg[i] <= DATA_RESET;
            else if (reg_wr && reg_addr == data_addr[i])
                data_reg[i] <= reg_wdata;
        end

        always_ff @(posedge ref_clk or posedge sys_rst)
        begin
            if (sys_rst)
                count[i] <= COUNT_ZERO;
            // RULE3 write of start clears
            else if (start_wr[i])
                count[i] <= COUNT_ZERO;
            // RULE9 clear on match
            else if (match_hit[i])
                count[i] <= COUNT_ZERO;
            // RULE8 capture mode keeps counting and wraps
            else if (run[i] && tick[i])
                count[i] <= count[i] + COUNT_ONE;
        end

        // RULE8 copy of the running count
        // No run gating, a stopped timer still latches
        always_ff @(posedge ref_clk or posedge sys_rst)
        begin
            if (sys_rst)
                capt[i] <= COUNT_ZERO;
            else if (capt_hit[i])
                capt[i] <= count[i];
        end
    end

    // ********************************
    // Interrupts
    // ********************************
    assign irq_set[EV_MATCH_A] = match_hit[TIMER_A];
    assign irq_set[EV_MATCH_C] = match_hit[TIMER_C];
    assign irq_set[EV_CAPT_A] = capt_hit[TIMER_A];
    assign irq_set[EV_CAPT_C] = capt_hit[TIMER_C];
    assign irq_clear = (reg_wr && reg_addr == ADDR_IRQ_CLEAR) ?
                       reg_wdata[EV_W-1:0] : STATUS_RESET;

    // Set beats clear so no event is lost
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq_status <= STATUS_RESET;
        else
            irq_status <= (irq_status & ~irq_clear) | irq_set;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq_enable <= STATUS_RESET;
        else if (reg_wr && reg_addr == ADDR_IRQ_ENABLE)
            irq_enable <= reg_wdata[EV_W-1:0];
    end

    // Registered output, one cycle behind status
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_enable);
    end

    // ********************************
    // Register read
    // ********************************
    always_comb
    begin
        next_rdata = DATA_RESET;
        case (reg_addr)
            ADDR_DATA_A: next_rdata = data_reg[TIMER_A];
            ADDR_DATA_C: next_rdata = data_reg[TIMER_C];
            ADDR_MODE_A: next_rdata = {2'h0, mode[TIMER_A]};
            ADDR_MODE_C: next_rdata = {2'h0, mode[TIMER_C]};
            ADDR_COUNT_A: next_rdata = count[TIMER_A];
            ADDR_COUNT_C: next_rdata = count[TIMER_C];
            ADDR_CAPT_A: next_rdata = capt[TIMER_A];
            ADDR_CAPT_C: next_rdata = capt[TIMER_C];
            ADDR_IRQ_STATUS: next_rdata = {4'h0, irq_status};
            ADDR_IRQ_ENABLE: next_rdata = {4'h0, irq_enable};
            default: next_rdata = DATA_RESET;
        endcase
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= DATA_RESET;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= DATA_RESET;
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    capture_copy_a: assert property ( // RULE8
        capt_hit[TIMER_A] |=> capt[TIMER_A] == $past(count[TIMER_A]))
        else $error("capture did not copy the count");

    capture_select_a: assert property ( // RULE1
        !mode[TIMER_C].capture |=> capt[TIMER_C] == $past(capt[TIMER_C]))
        else $error("capture happened in timer mode");

    pause_hold_a: assert property ( // RULE2
        !mode[TIMER_A].count_continue && !start_wr[TIMER_A]
        |=> count[TIMER_A] == $past(count[TIMER_A]))
        else $error("paused counter moved");

    start_clear_a: assert property ( // RULE3
        start_wr[TIMER_C] |=> count[TIMER_C] == COUNT_ZERO ##1
        mode[TIMER_C].start_clear)
        else $error("start write did not clear and hold start");

    stop_hold_a: assert property ( // RULE3
        !mode[TIMER_C].start_clear && !start_wr[TIMER_C]
        |=> $stable(count[TIMER_C]))
        else $error("stopped counter moved");

    // Code 100 must take the divide by 2^7 tap, not a neighbour
    div_code_a: assert property ( // RULE4
        mode[TIMER_A].clk_sel == 3'h4 |-> tick[TIMER_A] == div_tick[7])
        else $error("timer A code 100 on the wrong rate");

    c_reserved_a: assert property ( // RULE5
        mode[TIMER_C].clk_sel == CLK_SEL_EXT |-> !tick[TIMER_C])
        else $error("reserved clock code ticked");

    c_reset_a: assert property ( // RULE6
        disable iff (1'b0)
        sys_rst ##1 !reg_wr |-> mode[TIMER_C] == MODE_RESET)
        else $error("timer C mode not cleared by reset");

    event_count_a: assert property ( // RULE7
        mode[TIMER_A].clk_sel == CLK_SEL_EXT && run[TIMER_A] &&
        !mode[TIMER_A].capture && event_rise && !start_wr[TIMER_A] &&
        count[TIMER_A] != data_reg[TIMER_A]
        |=> count[TIMER_A] == $past(count[TIMER_A]) + COUNT_ONE)
        else $error("pin edge not counted once");

    match_clear_a: assert property ( // RULE9
        match_hit[TIMER_A]
        |=> count[TIMER_A] == COUNT_ZERO && irq_status[EV_MATCH_A])
        else $error("match did not clear and flag");

    irq_level_a: assert property (
        |(irq_status & irq_enable) |=> irq)
        else $error("enabled status without interrupt");

    irq_drop_a: assert property (
        !(|(irq_status & irq_enable)) |=> !irq)
        else $error("interrupt without enabled status");

    status_sticky_a: assert property (
        irq_status[EV_CAPT_A] && !irq_clear[EV_CAPT_A]
        |=> irq_status[EV_CAPT_A])
        else $error("status bit dropped without a clear");

    tick_gap_a: assert property (
        div_tick[DIV_MAX] |=> !div_tick[DIV_MAX] [*8])
        else $error("slowest rate ticked too soon");

    c_copy_a: assert property ( // RULE8
        capt_hit[TIMER_C] |=> capt[TIMER_C] == $past(count[TIMER_C]))
        else $error("timer C capture did not copy the count");

    a_select_a: assert property ( // RULE1
        !mode[TIMER_A].capture |=> capt[TIMER_A] == $past(capt[TIMER_A]))
        else $error("timer A captured in timer mode");

    capt_wrap_a: assert property ( // RULE8
        run[TIMER_A] && mode[TIMER_A].capture && tick[TIMER_A] &&
        !start_wr[TIMER_A]
        |=> count[TIMER_A] == $past(count[TIMER_A]) + COUNT_ONE)
        else $error("capture mode stopped counting");

    c_pause_a: assert property ( // RULE2
        !mode[TIMER_C].count_continue && !start_wr[TIMER_C]
        |=> count[TIMER_C] == $past(count[TIMER_C]))
        else $error("paused timer C moved");

    a_stop_a: assert property ( // RULE3
        !mode[TIMER_A].start_clear && !start_wr[TIMER_A]
        |=> $stable(count[TIMER_A]))
        else $error("stopped timer A moved");

    c_match_a: assert property ( // RULE9
        match_hit[TIMER_C]
        |=> count[TIMER_C] == COUNT_ZERO && irq_status[EV_MATCH_C])
        else $error("timer C match did not clear and flag");

    mode_write_a: assert property ( // RULE1
        reg_wr && reg_addr == ADDR_MODE_C
        |=> mode[TIMER_C] == $past(reg_wdata[MODE_W-1:0]))
        else $error("mode write did not land");

    data_write_a: assert property ( // RULE9
        reg_wr && reg_addr == ADDR_DATA_A
        |=> data_reg[TIMER_A] == $past(reg_wdata))
        else $error("data write did not land");

    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == DATA_RESET)
        else $error("read data outside the read cycle");

    // ********************************
    // Cover points
    // ********************************
    cover_event_count: cover property (
        mode[TIMER_A].clk_sel == CLK_SEL_EXT && run[TIMER_A] && event_rise);
    cover_capture: cover property (capt_hit[TIMER_C]);
    cover_match_irq: cover property (match_hit[TIMER_A] ##[1:3] irq);
    cover_match_c: cover property (match_hit[TIMER_C]);
    cover_stop_capture: cover property (capt_hit[TIMER_C] && !run[TIMER_C]);

endmodule // timer_pair_mode_control
`default_nettype wire

/* File: hdl/timer_pkg.sv */
package timer_pkg;

    // ********************************
    // Widths
    // ********************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int MODE_W = 6;
    localparam int DIV_MAX = 12;
    localparam int EV_W = 4;
    localparam int NUM_TIMERS = 2;
    localparam int TIMER_A = 0;
    localparam int TIMER_C = 1;

    // ********************************
    // Mode register layout
    // ********************************
    typedef struct packed {
        logic capture;
        logic [2:0] clk_sel;
        logic count_continue;
        logic start_clear;
    } mode_t;

    localparam mode_t MODE_RESET = 6'h00;
    localparam logic [2:0] CLK_SEL_EXT = 3'h7;

    // ********************************
    // Register map
    // ********************************
    localparam logic [ADDR_W-1:0] ADDR_DATA_A = 8'hD0;
    localparam logic [ADDR_W-1:0] ADDR_DATA_C = 8'hD1;
    localparam logic [ADDR_W-1:0] ADDR_MODE_A = 8'hD4;
    localparam logic [ADDR_W-1:0] ADDR_MODE_C = 8'hD6;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_A = 8'hD8;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_C = 8'hD9;
    localparam logic [ADDR_W-1:0] ADDR_CAPT_A = 8'hDA;
    localparam logic [ADDR_W-1:0] ADDR_CAPT_C = 8'hDB;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'hE0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 8'hE1;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'hE2;

    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_ONE = 8'h01;
    localparam logic [EV_W-1:0] STATUS_RESET = 4'h0;

    // ********************************
    // Interrupt status bits
    // ********************************
    localparam int EV_MATCH_A = 0;
    localparam int EV_MATCH_C = 1;
    localparam int EV_CAPT_A = 2;
    localparam int EV_CAPT_C = 3;

    // Divider exponent for a clock code, 0 means no prescaler tick
    function automatic int div_exponent(input logic [2:0] code,
                                        input logic is_c);
        int e;
        e = 0;
        if (code == 3'h0)
            e = 1;
        else if (code == 3'h1)
            e = 2;
        else if (code != CLK_SEL_EXT)
            e = is_c ? 2 * int'(code) : 2 * int'(code) - 1;
        return e;
    endfunction

endpackage

/* File: hdl/clock_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Division enables, bit k pulses once every 2^k cycles
    output logic [DIV_MAX:1] div_tick
);

    localparam logic [DIV_MAX-1:0] DIV_ONE = 12'h001;

    logic [DIV_MAX-1:0] div_count;
    logic [DIV_MAX:1] next_tick;
    logic ones_run;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            div_count <= '0;
        else
            div_count <= div_count + DIV_ONE;
    end

    // Tap k fires when the low k bits are all ones, once every 2^k cycles
    always_comb
    begin
        ones_run = 1'b1;
        next_tick = '0;
        for (int k = 1; k <= DIV_MAX; k++)
        begin
            ones_run = ones_run & div_count[k-1];
            next_tick[k] = ones_run;
        end
    end

    // Free running, so all rates stay phase aligned
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            div_tick <= '0;
        else
            div_tick <= next_tick;
    end

endmodule // clock_prescaler
`default_nettype wire

/* File: hdl/edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Asynchronous pins
    input wire logic [W-1:0] pin_in,
    // One-cycle pulse per low-to-high change
    output logic [W-1:0] rise_out
);

    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] last;

    // First stage read only by the second
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta <= '0;
            stable <= '0;
            last <= '0;
        end
        else
        begin
            meta <= pin_in;
            stable <= meta;
            last <= stable;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rise_out <= '0;
        else
            rise_out <= stable & ~last;
    end

endmodule // edge_sync
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import timer_pkg::*;
;
    // ********************************
    // Signals
    // ********************************
    logic ref_clk;
    logic sys_rst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic [2:0] pins;
    logic irq;
    int err_total;
    int check_count;
    int ea[7] = '{1, 2, 3, 5, 7, 9, 11};
    int ec[7] = '{1, 2, 4, 6, 8, 10, 12};

    timer_pair_mode_control dut
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .external_event_input(pins[0]),
        .capture_a_pin(pins[1]),
        .capture_c_pin(pins[2]),
        .irq(irq)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ********************************
    // Shared tasks
    // ********************************
    task automatic test_done;
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // Idle edge keeps back-to-back writes from driving reg_wr twice
        @(posedge ref_clk);
    endtask

    // Data sampled mid-cycle, it stands for one cycle only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
        @(posedge ref_clk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic chk_irq(input logic e);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({7'h00, irq}, {7'h00, e});
        @(posedge ref_clk);
    endtask

    // Pins held 4 cycles per level, beyond the 2-cycle minimum
    task automatic pulse(input int i);
        pins[i] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pins[i] <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    // Ticks over exactly two periods, independent of prescaler phase
    task automatic rate(input logic [7:0] ma, input logic [7:0] ca,
                        input logic [2:0] code, input int e,
                        input logic [7:0] exp);
        logic [7:0] a;
        logic [7:0] b;
        wr(ma, {3'h0, code, 2'h3});
        rd(ca, a);
        repeat ((2 << e) - 2) @(posedge ref_clk);
        rd(ca, b);
        chk(b - a, exp);
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_regs;
        rdc(ADDR_MODE_C, 8'h00);
        rdc(ADDR_MODE_A, 8'h00);
        rdc(ADDR_IRQ_STATUS, 8'h00);
        chk_irq(1'b0);
        wr(ADDR_MODE_C, 8'hFF);
        rdc(ADDR_MODE_C, 8'h3F);
        rdc(8'h55, 8'h00);
        rdc(ADDR_IRQ_CLEAR, 8'h00);
        wr(ADDR_MODE_C, 8'h00);
    endtask

    task automatic t_rates;
        wr(ADDR_DATA_A, 8'hFF);
        wr(ADDR_DATA_C, 8'hFF);
        for (int i = 0; i < 7; i++)
            rate(ADDR_MODE_A, ADDR_COUNT_A, i[2:0], ea[i], 8'h02);
        for (int i = 0; i < 7; i++)
            rate(ADDR_MODE_C, ADDR_COUNT_C, i[2:0], ec[i], 8'h02);
        rate(ADDR_MODE_C, ADDR_COUNT_C, 3'h7, 5, 8'h00);
    endtask

    task automatic t_pause;
        logic [7:0] a;
        logic [7:0] b;
        wr(ADDR_MODE_C, 8'h03);
        repeat (40) @(posedge ref_clk);
        wr(ADDR_MODE_C, 8'h02);
        rd(ADDR_COUNT_C, a);
        chk(a & 8'hF0, 8'h10);
        repeat (20) @(posedge ref_clk);
        rd(ADDR_COUNT_C, b);
        chk(b, a);
        wr(ADDR_MODE_C, 8'h01);
        rd(ADDR_COUNT_C, a);
        repeat (20) @(posedge ref_clk);
        rd(ADDR_COUNT_C, b);
        chk(a, 8'h00);
        chk(b, 8'h00);
        wr(ADDR_DATA_C, 8'h03);
        wr(ADDR_MODE_C, 8'h03);
        rd(ADDR_COUNT_C, a);
        chk(a & 8'hFE, 8'h00);
        repeat (16) @(posedge ref_clk);
        rdc(ADDR_IRQ_STATUS, 8'h02);
        wr(ADDR_MODE_C, 8'h00);
    endtask

    task automatic t_events;
        wr(ADDR_IRQ_ENABLE, 8'h00);
        wr(ADDR_DATA_A, 8'h02);
        rdc(ADDR_DATA_A, 8'h02);
        wr(ADDR_MODE_A, 8'h1F);
        wr(ADDR_IRQ_CLEAR, 8'h0F);
        pulse(0);
        pulse(0);
        rdc(ADDR_COUNT_A, 8'h02);
        rdc(ADDR_IRQ_STATUS, 8'h00);
        pulse(0);
        rdc(ADDR_COUNT_A, 8'h00);
        rdc(ADDR_IRQ_STATUS, 8'h01);
        chk_irq(1'b0);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        chk_irq(1'b1);
        rdc(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_IRQ_CLEAR, 8'h01);
        chk_irq(1'b0);
        pulse(1);
        rdc(ADDR_IRQ_STATUS, 8'h00);
    endtask

    task automatic t_capture;
        logic [7:0] a;
        logic [7:0] b;
        wr(ADDR_MODE_A, 8'h3F);
        repeat (5) pulse(0);
        rdc(ADDR_COUNT_A, 8'h05);
        pulse(1);
        rdc(ADDR_CAPT_A, 8'h05);
        rdc(ADDR_IRQ_STATUS, 8'h04);
        // Stopped timer still captures
        wr(ADDR_MODE_C, 8'h23);
        repeat (20) @(posedge ref_clk);
        wr(ADDR_MODE_C, 8'h20);
        rd(ADDR_COUNT_C, a);
        pulse(2);
        rd(ADDR_COUNT_C, b);
        chk(b, a);
        rdc(ADDR_CAPT_C, a);
        rdc(ADDR_IRQ_STATUS, 8'h0C);
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial
    begin
        err_total = 0;
        check_count = 0;
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        pins = 3'h0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_regs;
        t_rates;
        t_pause;
        t_events;
        t_capture;
        test_done;
    end

    // Well above the roughly 17000 cycles the scenarios take
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        err_total++;
        test_done;
    end
endmodule // tb_top
`default_nettype wire
